/* File: rtl/clk_ctl_pkg.sv */
// Constants and carrier types for the DAC clock control block
// How it works
// - Multiplier enable set: input clock is data rate; clear: sample rate, bypassed.
// - Derive aligned 1x, 2x, 4x and 8x clock enables for downstream logic.
// - Lock status drives the lock pin and bit 1 of register 00h.
// - Oscillator rate equals data rate times interpolation times prescaler.
// - Zero stuffing doubles the oscillator rate once more.
// - Lock indicator on shared data clock pin, or serial out pin when moved.
package clk_ctl_pkg;

   // ----------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [5:0] IDX_STATUS   = 6'h00;
   localparam logic [5:0] IDX_PINSEL   = 6'h01;
   localparam logic [5:0] IDX_PLLCTL   = 6'h02;
   localparam logic [5:0] IDX_OUTLOC   = 6'h03;
   localparam logic [5:0] IDX_CFG      = 6'h05;
   localparam logic [5:0] IDX_IRQ_ST   = 6'h06;
   localparam logic [5:0] IDX_IRQ_MASK = 6'h07;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int POS_LOCK      = 1;
   localparam int POS_DCLK_SEL  = 0;
   localparam int POS_PLL_EN    = 7;
   localparam int POS_OUT_LOC   = 7;
   localparam int POS_INTERP    = 0;
   localparam int POS_PRESC     = 2;
   localparam int POS_ZSTUFF    = 4;
   localparam int POS_IRQ_GAIN  = 0;
   localparam int POS_IRQ_LOSS  = 1;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic       RST_PLL_EN   = 1'b0;
   localparam logic       RST_DCLK_SEL = 1'b0;
   localparam logic       RST_OUT_LOC  = 1'b0;
   localparam logic [1:0] RST_INTERP   = 2'h0;
   localparam logic [1:0] RST_PRESC    = 2'h0;
   localparam logic       RST_ZSTUFF   = 1'b0;
   localparam logic [1:0] RST_IRQ      = 2'h0;

   // ----------------------------------------------------------------
   // Timing counts
   // ----------------------------------------------------------------
   localparam int          PERIOD_W   = 16;
   localparam logic [3:0]  LOCK_EDGES = 4'h8;
   localparam logic [15:0] PER_MAX    = 16'hffff;

   // ----------------------------------------------------------------
   // Carrier types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic       pll_en;
      logic       dclk_sel;
      logic       out_loc;
      logic [1:0] interp_log2;
      logic [1:0] presc_log2;
      logic       zero_stuff;
   } clk_cfg_t;

   typedef struct packed {
      logic en_1x;
      logic en_2x;
      logic en_4x;
      logic en_8x;
   } clk_en_t;

endpackage : clk_ctl_pkg

/* File: rtl/tick_gen.sv */
// Programmable-period tick generator, restartable by a sync pulse
module tick_gen
   import clk_ctl_pkg::*;
(
   input  wire logic                clk_in,
   input  wire logic                rst_in,
   input  wire logic                run_in,
   input  wire logic                sync_in,
   input  wire logic [PERIOD_W-1:0] period_in,
   output logic                     tick_out
);

   logic [PERIOD_W-1:0] cnt_r;
   logic [PERIOD_W-1:0] cnt_nxt;
   logic                tick_r;
   logic                tick_nxt;

   // ----------------------------------------------------------------
   // Countdown
   // ----------------------------------------------------------------
   always_comb begin
      cnt_nxt  = cnt_r;
      tick_nxt = 1'b0;
      if (!run_in || period_in == '0) begin
         cnt_nxt = '0;
      end else if (sync_in || cnt_r == '0) begin
         cnt_nxt  = period_in - 16'h0001;
         tick_nxt = 1'b1;
      end else begin
         cnt_nxt = cnt_r - 16'h0001;
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         cnt_r  <= '0;
         tick_r <= 1'b0;
      end else begin
         cnt_r  <= cnt_nxt;
         tick_r <= tick_nxt;
      end
   end

   assign tick_out = tick_r;

endmodule // tick_gen

/* File: rtl/clk_ctl.sv */
// Clock control top: Wishbone registers, lock detect, clock enables
module clk_ctl
   import clk_ctl_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   input  wire logic        wb_cyc_in,
   input  wire logic        wb_stb_in,
   input  wire logic        wb_we_in,
   input  wire logic [31:0] wb_adr_in,
   input  wire logic [31:0] wb_dat_in,
   input  wire logic [3:0]  wb_sel_in,
   output logic [31:0]      wb_dat_out,
   output logic             wb_ack_out,
   input  wire logic        sample_clock_input_in,
   output logic             lock_out,
   output logic             data_rate_clock_out,
   output logic             sdo_pin_out,
   output logic             osc_tick_out,
   output logic             clk_en_1x_out,
   output logic             clk_en_2x_out,
   output logic             clk_en_4x_out,
   output logic             clk_en_8x_out,
   output logic             irq_out
);

   // ----------------------------------------------------------------
   // Register bus
   // ----------------------------------------------------------------
   clk_cfg_t    cfg_r;
   clk_cfg_t    cfg_nxt;
   logic [1:0]  ist_r;
   logic [1:0]  ist_nxt;
   logic [1:0]  imask_r;
   logic [1:0]  imask_nxt;
   logic        ack_r;
   logic        ack_nxt;
   logic [31:0] dat_r;
   logic [31:0] dat_nxt;
   logic        irq_r;
   logic        irq_nxt;
   logic        lock_r;
   logic        lock_nxt;
   logic [5:0]  idx;
   logic        hit;
   logic        wr;
   logic [1:0]  ev_set;

   assign idx    = wb_adr_in[7:2];
   assign hit    = wb_cyc_in && wb_stb_in && !ack_r;
   assign wr     = hit && wb_we_in && wb_sel_in[0]
                   && wb_adr_in[31:8] == 24'h000000;
   assign ev_set = {lock_r && !lock_nxt, !lock_r && lock_nxt};

   always_comb begin
      cfg_nxt   = cfg_r;
      imask_nxt = imask_r;
      ist_nxt   = ist_r;
      ack_nxt   = hit;
      dat_nxt   = 32'h00000000;
      if (wr) begin
         if (idx == IDX_PINSEL) begin
            cfg_nxt.dclk_sel = wb_dat_in[POS_DCLK_SEL];
         end else if (idx == IDX_PLLCTL) begin
            cfg_nxt.pll_en = wb_dat_in[POS_PLL_EN];
         end else if (idx == IDX_OUTLOC) begin
            cfg_nxt.out_loc = wb_dat_in[POS_OUT_LOC];
         end else if (idx == IDX_CFG) begin
            cfg_nxt.interp_log2 = wb_dat_in[POS_INTERP +: 2];
            cfg_nxt.presc_log2  = wb_dat_in[POS_PRESC +: 2];
            cfg_nxt.zero_stuff  = wb_dat_in[POS_ZSTUFF];
         end else if (idx == IDX_IRQ_ST) begin
            ist_nxt = ist_r & ~wb_dat_in[1:0];
         end else if (idx == IDX_IRQ_MASK) begin
            imask_nxt = wb_dat_in[1:0];
         end
      end
      ist_nxt = ist_nxt | ev_set;
      if (hit && !wb_we_in && wb_adr_in[31:8] == 24'h000000) begin
         if (idx == IDX_STATUS) begin
            dat_nxt[POS_LOCK] = lock_r;
         end else if (idx == IDX_PINSEL) begin
            dat_nxt[POS_DCLK_SEL] = cfg_r.dclk_sel;
         end else if (idx == IDX_PLLCTL) begin
            dat_nxt[POS_PLL_EN] = cfg_r.pll_en;
         end else if (idx == IDX_OUTLOC) begin
            dat_nxt[POS_OUT_LOC] = cfg_r.out_loc;
         end else if (idx == IDX_CFG) begin
            dat_nxt[POS_INTERP +: 2] = cfg_r.interp_log2;
            dat_nxt[POS_PRESC +: 2]  = cfg_r.presc_log2;
            dat_nxt[POS_ZSTUFF]      = cfg_r.zero_stuff;
         end else if (idx == IDX_IRQ_ST) begin
            dat_nxt[1:0] = ist_r;
         end else if (idx == IDX_IRQ_MASK) begin
            dat_nxt[1:0] = imask_r;
         end
      end
      irq_nxt = |(ist_r & imask_r);
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         cfg_r   <= {RST_PLL_EN, RST_DCLK_SEL, RST_OUT_LOC, RST_INTERP,
                     RST_PRESC, RST_ZSTUFF};
         ist_r   <= RST_IRQ;
         imask_r <= RST_IRQ;
         ack_r   <= 1'b0;
         dat_r   <= 32'h00000000;
         irq_r   <= 1'b0;
      end else begin
         cfg_r   <= cfg_nxt;
         ist_r   <= ist_nxt;
         imask_r <= imask_nxt;
         ack_r   <= ack_nxt;
         dat_r   <= dat_nxt;
         irq_r   <= irq_nxt;
      end
   end

   assign wb_ack_out = ack_r;
   assign wb_dat_out = dat_r;
   assign irq_out    = irq_r;

   // ----------------------------------------------------------------
   // Reference edge and lock detect
   // ----------------------------------------------------------------
   logic                ref_prev_r;
   logic                ref_edge;
   logic [PERIOD_W-1:0] per_cnt_r;
   logic [PERIOD_W-1:0] per_cnt_nxt;
   logic [PERIOD_W-1:0] ref_per_r;
   logic [PERIOD_W-1:0] ref_per_nxt;
   logic [3:0]          stable_r;
   logic [3:0]          stable_nxt;
   logic [PERIOD_W-1:0] per_diff;

   assign ref_edge = sample_clock_input_in && !ref_prev_r;
   assign per_diff = (per_cnt_r > ref_per_r) ? per_cnt_r - ref_per_r
                                             : ref_per_r - per_cnt_r;

   always_comb begin
      per_cnt_nxt = per_cnt_r;
      ref_per_nxt = ref_per_r;
      stable_nxt  = stable_r;
      lock_nxt    = lock_r;
      if (!cfg_r.pll_en) begin
         stable_nxt = 4'h0;
         lock_nxt   = 1'b0;
      end else if (ref_edge) begin
         per_cnt_nxt = 16'h0001;
         ref_per_nxt = per_cnt_r;
         if (per_diff <= 16'h0001 && per_cnt_r != PER_MAX) begin
            if (stable_r != LOCK_EDGES) begin
               stable_nxt = stable_r + 4'h1;
            end
         end else begin
            stable_nxt = 4'h0;
         end
         lock_nxt = (stable_nxt == LOCK_EDGES);
      end else if (per_cnt_r == PER_MAX) begin
         stable_nxt = 4'h0;
         lock_nxt   = 1'b0;
      end else begin
         per_cnt_nxt = per_cnt_r + 16'h0001;
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         ref_prev_r <= 1'b0;
         per_cnt_r  <= '0;
         ref_per_r  <= '0;
         stable_r   <= 4'h0;
         lock_r     <= 1'b0;
      end else begin
         ref_prev_r <= sample_clock_input_in;
         per_cnt_r  <= per_cnt_nxt;
         ref_per_r  <= ref_per_nxt;
         stable_r   <= stable_nxt;
         lock_r     <= lock_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Oscillator and 8x tick generators
   // ----------------------------------------------------------------
   logic [2:0]          osc_sh;
   logic [PERIOD_W-1:0] osc_per_r;
   logic [PERIOD_W-1:0] osc_per_nxt;
   logic [PERIOD_W-1:0] fast_per;
   logic                tick8;

   assign osc_sh = {1'b0, cfg_r.interp_log2} + {1'b0, cfg_r.presc_log2}
                   + {2'h0, cfg_r.zero_stuff};
   assign osc_per_nxt = ref_per_r >> osc_sh;
   assign fast_per    = ref_per_r >> 3;

   tick_gen u_osc (
      .clk_in    (clk_in),
      .rst_in    (rst_in),
      .run_in    (cfg_r.pll_en),
      .sync_in   (ref_edge),
      .period_in (osc_per_r),
      .tick_out  (osc_tick_out)
   );

   tick_gen u_fast (
      .clk_in    (clk_in),
      .rst_in    (rst_in),
      .run_in    (cfg_r.pll_en),
      .sync_in   (ref_edge),
      .period_in (fast_per),
      .tick_out  (tick8)
   );

   // ----------------------------------------------------------------
   // Aligned clock enables and pins
   // ----------------------------------------------------------------
   clk_en_t    en_r;
   clk_en_t    en_nxt;
   logic [2:0] phase_r;
   logic [2:0] phase_nxt;
   logic       dclk_r;
   logic       dclk_nxt;
   logic       pin8_r;
   logic       pin8_nxt;
   logic       pin53_r;
   logic       pin53_nxt;
   logic       lockp_r;
   logic       fast;
   logic       show_lock;

   // Bypass: each input edge is the top rate; else the 8x tick
   assign fast      = cfg_r.pll_en ? tick8 : ref_edge;
   assign show_lock = cfg_r.pll_en && !cfg_r.dclk_sel;

   always_comb begin
      phase_nxt = phase_r;
      dclk_nxt  = dclk_r;
      en_nxt    = '0;
      if (fast) begin
         phase_nxt    = phase_r + 3'h1;
         en_nxt.en_8x = 1'b1;
         en_nxt.en_4x = (phase_r[0] == 1'b0);
         en_nxt.en_2x = (phase_r[1:0] == 2'h0);
         en_nxt.en_1x = (phase_r == 3'h0);
         if (phase_r[1:0] == 2'h0) begin
            dclk_nxt = !dclk_r;
         end
      end
      if (show_lock) begin
         pin8_nxt  = cfg_r.out_loc ? 1'b0 : lock_r;
         pin53_nxt = cfg_r.out_loc ? lock_r : 1'b0;
      end else begin
         pin8_nxt  = cfg_r.out_loc ? 1'b0 : dclk_r;
         pin53_nxt = cfg_r.out_loc ? dclk_r : 1'b0;
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         phase_r <= 3'h0;
         dclk_r  <= 1'b0;
         en_r    <= '0;
         pin8_r  <= 1'b0;
         pin53_r <= 1'b0;
         lockp_r <= 1'b0;
         osc_per_r <= '0;
      end else begin
         phase_r <= phase_nxt;
         dclk_r  <= dclk_nxt;
         en_r    <= en_nxt;
         pin8_r  <= pin8_nxt;
         pin53_r <= pin53_nxt;
         lockp_r <= lock_r;
         osc_per_r <= osc_per_nxt;
      end
   end

   assign clk_en_1x_out       = en_r.en_1x;
   assign clk_en_2x_out       = en_r.en_2x;
   assign clk_en_4x_out       = en_r.en_4x;
   assign clk_en_8x_out       = en_r.en_8x;
   assign data_rate_clock_out = pin8_r;
   assign sdo_pin_out         = pin53_r;
   assign lock_out            = lockp_r;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking ast_cb @(posedge clk_in);
   endclocking
   default disable iff (rst_in);

   AST_LOCK_READ: assert property (
      (hit && !wb_we_in && wb_adr_in == 32'h00000000) |=> wb_ack_out
      && wb_dat_out[POS_LOCK] == $past(lock_r) && !wb_dat_out[0])
      else $error("lock status read wrong");
   AST_LOCK_PIN: assert property (lock_r |=> lock_out)
      else $error("lock pin does not follow lock");
   AST_PIN8_LOCK: assert property (
      (cfg_r.pll_en && !cfg_r.dclk_sel && !cfg_r.out_loc)
      |=> data_rate_clock_out == $past(lock_r) && !sdo_pin_out)
      else $error("lock not on shared data clock pin");
   AST_PIN53_LOCK: assert property (
      (cfg_r.pll_en && !cfg_r.dclk_sel && cfg_r.out_loc)
      |=> sdo_pin_out == $past(lock_r) && !data_rate_clock_out)
      else $error("lock not on serial out pin");
   AST_BYPASS_UNLOCK: assert property (
      !cfg_r.pll_en |=> !lock_r ##1 !lock_out)
      else $error("lock reported with multiplier bypassed");
   AST_BYPASS_RATE: assert property (
      (!cfg_r.pll_en && ref_edge) |=> clk_en_8x_out)
      else $error("bypass edge gave no top rate enable");
   AST_EN_SYNC: assert property (
      clk_en_1x_out |-> clk_en_2x_out && clk_en_4x_out && clk_en_8x_out)
      else $error("clock enables not aligned");
   AST_EN_RATIO: assert property (
      (clk_en_4x_out && !clk_en_2x_out) |-> clk_en_8x_out
      && ($past(phase_r) == 3'h2 || $past(phase_r) == 3'h6))
      else $error("4x enable off its phase");
   AST_OSC_RATE: assert property (
      !$past(cfg_r.zero_stuff) |-> osc_per_r == ($past(ref_per_r)
      >> ({1'b0, $past(cfg_r.interp_log2)}
      + {1'b0, $past(cfg_r.presc_log2)})))
      else $error("oscillator period wrong");
   AST_OSC_ZSTUFF: assert property (
      $past(cfg_r.zero_stuff) |-> osc_per_r == (($past(ref_per_r)
      >> ({1'b0, $past(cfg_r.interp_log2)}
      + {1'b0, $past(cfg_r.presc_log2)})) >> 1))
      else $error("zero stuffing did not double oscillator");
   AST_IRQ_LEVEL: assert property ((|(ist_r & imask_r)) |=> irq_out)
      else $error("unmasked event gave no interrupt");
   AST_ACK_ONE: assert property (wb_ack_out |=> !wb_ack_out)
      else $error("ack held two cycles");

endmodule // clk_ctl

/* File: tb/clk_src_model.sv */
// External sample clock source model with a programmable period
module clk_src_model (
   input  wire logic       clk_in,
   input  wire logic       rst_in,
   input  wire logic       run_in,
   input  wire logic [7:0] period_in,
   output logic            clk_out
);
   timeunit 1ns;
   timeprecision 1ps;

   // ----------------------------------------------------------------
   // Period counter, square wave, still low while stopped
   // ----------------------------------------------------------------
   logic [7:0] cnt_r;

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         cnt_r   <= 8'h00;
         clk_out <= 1'b0;
      end else if (!run_in) begin
         cnt_r   <= 8'h00;
         clk_out <= 1'b0;
      end else begin
         cnt_r   <= (cnt_r >= period_in - 8'h01) ? 8'h00 : cnt_r + 8'h01;
         clk_out <= (cnt_r < (period_in >> 1));
      end
   end
endmodule // clk_src_model

/* File: tb/test_clk_ctl.sv */
// Self-checking testbench for the DAC clock control block
module test_clk_ctl;
   import clk_ctl_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic        clk_in, rst_in, cyc, stb, we, src_run, ref_clk;
   logic [31:0] adr, wdat, rd, wb_dat_out;
   logic [3:0]  sel;
   logic [7:0]  period;
   logic        wb_ack_out, lock_out, data_rate_clock_out, sdo_pin_out;
   logic        osc_tick_out, irq_out, dclk_q, cnt_on;
   logic        clk_en_1x_out, clk_en_2x_out, clk_en_4x_out, clk_en_8x_out;
   int          err_count, n_tests, n1, n2, n4, n8, nosc, dtog, w;
   logic [4:0]  cfgv [4] = '{5'h05, 5'h15, 5'h03, 5'h0c};
   int          perv [4] = '{8, 4, 4, 4};

   clk_ctl dut_u (.clk_in(clk_in), .rst_in(rst_in), .wb_cyc_in(cyc),
      .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_dat_in(wdat),
      .wb_sel_in(sel), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
      .sample_clock_input_in(ref_clk), .lock_out(lock_out),
      .data_rate_clock_out(data_rate_clock_out), .sdo_pin_out(sdo_pin_out),
      .osc_tick_out(osc_tick_out), .clk_en_1x_out(clk_en_1x_out),
      .clk_en_2x_out(clk_en_2x_out), .clk_en_4x_out(clk_en_4x_out),
      .clk_en_8x_out(clk_en_8x_out), .irq_out(irq_out));

   clk_src_model src_u (.clk_in(clk_in), .rst_in(rst_in), .run_in(src_run),
      .period_in(period), .clk_out(ref_clk));

   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end

   // ----------------------------------------------------------------
   // Pulse counters
   // ----------------------------------------------------------------
   always @(posedge clk_in) begin
      if (cnt_on) begin
         n1   += (clk_en_1x_out === 1'b1);
         n2   += (clk_en_2x_out === 1'b1);
         n4   += (clk_en_4x_out === 1'b1);
         n8   += (clk_en_8x_out === 1'b1);
         nosc += (osc_tick_out === 1'b1);
         dtog += (data_rate_clock_out !== dclk_q);
      end
      dclk_q = data_rate_clock_out;
   end

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic close_out;
      if (err_count == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cmp_near(input int got, input int exp);
      n_tests++;
      if (got < exp - 2 || got > exp + 2) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wb_xfer(input logic w_en, input logic [31:0] a,
                          input logic [31:0] d);
      @(posedge clk_in);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w_en;
      adr  <= a;
      wdat <= d;
      do begin
         @(posedge clk_in);
      end while (wb_ack_out !== 1'b1);
      rd = wb_dat_out;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
   endtask

   task automatic rd_cmp(input logic [31:0] a, input logic [31:0] exp);
      wb_xfer(1'b0, a, 32'h0);
      cmp(rd, exp);
   endtask

   task automatic count(input int c);
      n1 = 0; n2 = 0; n4 = 0; n8 = 0; nosc = 0; dtog = 0;
      cnt_on <= 1'b1;
      repeat (c) @(posedge clk_in);
      cnt_on <= 1'b0;
      @(negedge clk_in);
   endtask

   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      rst_in = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 32'h0;
      wdat = 32'h0; sel = 4'hf; src_run = 1'b0; period = 8'h04;
      cnt_on = 1'b0; err_count = 0; n_tests = 0; dclk_q = 1'b0;
      repeat (2) @(posedge clk_in);
      rst_in <= 1'b0;
      foreach (cfgv[i]) rd_cmp(32'h04 + 32'(i) * 4, 32'h0);
      rd_cmp(32'h18, 32'h0);
      rd_cmp(32'h1c, 32'h0);
      rd_cmp(32'h00, 32'h0);
      wb_xfer(1'b1, 32'h10, 32'hff);
      rd_cmp(32'h10, 32'h0);
      sel <= 4'he;
      wb_xfer(1'b1, 32'h1c, 32'h3);
      sel <= 4'hf;
      rd_cmp(32'h1c, 32'h0);
      wb_xfer(1'b1, 32'h00, 32'hff);
      rd_cmp(32'h00, 32'h0);
      // Bypass: each input edge is one top-rate tick
      src_run <= 1'b1;
      repeat (20) @(posedge clk_in);
      count(400);
      cmp_near(n8, 100);
      cmp_near(n4, 50);
      cmp_near(n2, 25);
      cmp_near(n1, 12);
      cmp_near(dtog, 25);
      cmp(sdo_pin_out, 1'b0);
      cmp(lock_out, 1'b0);
      // Multiplier on, data rate kept inside the limits
      period <= 8'h20;
      wb_xfer(1'b1, 32'h14, 32'h05);
      wb_xfer(1'b1, 32'h08, 32'h80);
      w = 0;
      while (lock_out !== 1'b1 && w < 2000) begin
         @(posedge clk_in);
         w++;
      end
      cmp(lock_out, 1'b1);
      rd_cmp(32'h00, 32'h2);
      wb_xfer(1'b1, 32'h00, 32'h0);
      rd_cmp(32'h00, 32'h2);
      cmp(data_rate_clock_out, lock_out);
      rd_cmp(32'h18, 32'h1);
      cmp(irq_out, 1'b0);
      wb_xfer(1'b1, 32'h1c, 32'h1);
      repeat (2) @(posedge clk_in);
      cmp(irq_out, 1'b1);
      wb_xfer(1'b1, 32'h18, 32'h1);
      repeat (2) @(posedge clk_in);
      cmp(irq_out, 1'b0);
      rd_cmp(32'h18, 32'h0);
      wb_xfer(1'b1, 32'h0c, 32'h80);
      repeat (2) @(posedge clk_in);
      cmp(sdo_pin_out, 1'b1);
      cmp(data_rate_clock_out, 1'b0);
      wb_xfer(1'b1, 32'h04, 32'h1);
      wb_xfer(1'b1, 32'h0c, 32'h0);
      repeat (2) @(posedge clk_in);
      count(320);
      cmp_near(n8, 80);
      cmp_near(n1, 10);
      cmp_near(dtog, 20);
      cmp(sdo_pin_out, 1'b0);
      rd_cmp(32'h04, 32'h1);
      // Oscillator rate per interpolation, prescaler and stuffing
      foreach (cfgv[i]) begin
         wb_xfer(1'b1, 32'h14, {27'h0, cfgv[i]});
         repeat (64) @(posedge clk_in);
         count(320);
         cmp_near(nosc, 320 / perv[i]);
      end
      wb_xfer(1'b1, 32'h08, 32'h0);
      repeat (3) @(posedge clk_in);
      cmp(lock_out, 1'b0);
      rd_cmp(32'h00, 32'h0);
      rd_cmp(32'h18, 32'h2);
      close_out();
   end

   initial begin
      #300us;
      err_count++;
      close_out();
   end
endmodule // test_clk_ctl
